/* File: src/sram_host_cfg.svh */
// Notes on behaviour
// - host holds each read address at least 55/70 ns
// - host spaces write addresses at least 55/70 ns apart
// - host keeps select low 50/55 ns before strobe rises
// - address stable 15 ns before strobe falls, 50/55 ns before it rises
// - host holds write strobe low at least 35/40 ns
// - host drives data at least 25/30 ns before strobe rises
// - host holds address at least 5 ns after strobe rises
// - host holds data at least 5 ns after strobe rises
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH

`define SH_CLK_PERIOD_NS   5
`define SH_ADDR_W          16
`define SH_CNT_W           5
// slow grade figures, ns
`define SH_T_RC_NS         70
`define SH_T_AA_NS         70
`define SH_T_HZ_NS         40
`define SH_T_PD_NS         45
`define SH_T_AS_NS         15
`define SH_T_WP_NS         40
`define SH_T_CW_NS         55
`define SH_T_WC_NS         70
`define SH_T_HOLD_NS       5
// cycle counts: least times round up
`define SH_CYC_UP(t) (((t) + `SH_CLK_PERIOD_NS - 1) / `SH_CLK_PERIOD_NS)
`define SH_CYC_RD    `SH_CYC_UP(`SH_T_AA_NS)
`define SH_CYC_HZ    `SH_CYC_UP(`SH_T_HZ_NS)
`define SH_CYC_PD    `SH_CYC_UP(`SH_T_PD_NS)
`define SH_CYC_AS    `SH_CYC_UP(`SH_T_AS_NS)
`define SH_CYC_WP    `SH_CYC_UP(`SH_T_WP_NS)
`define SH_CYC_WC    `SH_CYC_UP(`SH_T_WC_NS)
`define SH_CYC_HOLD  `SH_CYC_UP(`SH_T_HOLD_NS)
// extra cycles for the pin synchroniser on the data output
`define SH_SYNC_LAT  2

`endif

/* File: src/sh_pkg.sv */
`include "sram_host_cfg.svh"
package sh_pkg;
  typedef enum logic [2:0] {
    SH_IDLE  = 3'b000,
    SH_RSET  = 3'b001,
    SH_RWAIT = 3'b010,
    SH_WSET  = 3'b011,
    SH_WPUL  = 3'b100,
    SH_WHOLD = 3'b101,
    SH_RECOV = 3'b110
  } sh_state_t;

  typedef struct packed {
    logic                  sel_n;
    logic                  wr_n;
    logic [`SH_ADDR_W-1:0] word_address;
    logic                  din;
  } sh_pins_t;

  typedef struct packed {
    logic                  write;
    logic [`SH_ADDR_W-1:0] addr;
    logic                  wdata;
  } sh_req_t;
endpackage

/* File: src/sh_sync.sv */
`timescale 1ns/100ps
`include "sram_host_cfg.svh"
module sh_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sh_sync_st_t;

  sh_sync_st_t st_reg;
  sh_sync_st_t st_next;

  // two flops, first read only by second
  always_comb begin
    st_next.meta = async_i;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.sync;
endmodule

/* File: src/sh_sram_host.sv */
`timescale 1ns/100ps
`include "sram_host_cfg.svh"
module sh_sram_host (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // user request side
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire sh_pkg::sh_req_t       req_i,
  output logic                       rd_valid_o,
  output logic                       rd_data_o,
  // memory pins
  output logic                       mem_sel_n_o,
  output logic                       mem_wr_n_o,
  output logic [`SH_ADDR_W-1:0]      mem_word_address_o,
  output logic                       mem_din_o,
  input  wire logic                  mem_dout_i
);
  typedef struct packed {
    sh_pkg::sh_state_t     state;
    logic [`SH_CNT_W-1:0]  cnt;
    sh_pkg::sh_pins_t      pins;
    logic                  rd_valid;
    logic                  rd_data;
  } sh_host_st_t;

  sh_host_st_t st_reg;
  sh_host_st_t st_next;
  logic        dout_sync;

  // data output pin passes two flops
  sh_sync u_dout_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (mem_dout_i),
    .sync_o    (dout_sync)
  );

  // cycle targets, cast to counter width
  localparam logic [`SH_CNT_W-1:0] RD_CYC =
    `SH_CNT_W'(`SH_CYC_RD + `SH_SYNC_LAT);
  localparam logic [`SH_CNT_W-1:0] AS_CYC   = `SH_CNT_W'(`SH_CYC_AS);
  localparam logic [`SH_CNT_W-1:0] WP_CYC   = `SH_CNT_W'(`SH_CYC_WP);
  localparam logic [`SH_CNT_W-1:0] HOLD_CYC = `SH_CNT_W'(`SH_CYC_HOLD);
  localparam logic [`SH_CNT_W-1:0] WC_CYC   = `SH_CNT_W'(`SH_CYC_WC);
  localparam logic [`SH_CNT_W-1:0] REC_CYC  =
    `SH_CNT_W'((`SH_CYC_HZ > `SH_CYC_PD) ? `SH_CYC_HZ : `SH_CYC_PD);
  localparam logic [`SH_CNT_W-1:0] CNT_ONE  = `SH_CNT_W'(1);

  // next state of the pin sequencer
  always_comb begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.cnt      = st_reg.cnt + CNT_ONE;
    unique case (st_reg.state)
      sh_pkg::SH_IDLE: begin
        st_next.cnt = '0;
        if (req_valid_i) begin
          // address and data set before any strobe
          st_next.pins.word_address = req_i.addr;
          st_next.pins.din          = req_i.wdata;
          st_next.pins.wr_n         = 1'b1;
          st_next.pins.sel_n        = 1'b0;
          st_next.state = req_i.write ? sh_pkg::SH_WSET
                                      : sh_pkg::SH_RSET;
        end
      end
      sh_pkg::SH_RSET: begin
        // read: select low, strobe high
        st_next.state = sh_pkg::SH_RWAIT;
      end
      sh_pkg::SH_RWAIT: begin
        // address held and sampled past access time
        if (st_reg.cnt >= RD_CYC) begin
          st_next.rd_data  = dout_sync;
          st_next.rd_valid = 1'b1;
          st_next.pins.sel_n = 1'b1;
          st_next.cnt      = '0;
          st_next.state    = sh_pkg::SH_RECOV;
        end
      end
      sh_pkg::SH_WSET: begin
        // address setup before strobe falls
        if (st_reg.cnt >= AS_CYC - CNT_ONE) begin
          st_next.pins.wr_n = 1'b0;
          st_next.cnt       = '0;
          st_next.state     = sh_pkg::SH_WPUL;
        end
      end
      sh_pkg::SH_WPUL: begin
        // strobe low long enough; select and data set
        if (st_reg.cnt >= WP_CYC - CNT_ONE) begin
          st_next.pins.wr_n = 1'b1; // ends write, latches din
          st_next.cnt       = '0;
          st_next.state     = sh_pkg::SH_WHOLD;
        end
      end
      sh_pkg::SH_WHOLD: begin
        // address and data held after strobe rise
        if (st_reg.cnt >= HOLD_CYC - CNT_ONE) begin
          st_next.pins.sel_n = 1'b1;
          st_next.cnt        = '0;
          st_next.state      = sh_pkg::SH_RECOV;
        end
      end
      sh_pkg::SH_RECOV: begin
        // wait out release and standby before next cycle
        if (st_reg.cnt >= REC_CYC - CNT_ONE) begin
          st_next.state = sh_pkg::SH_IDLE;
        end
      end
      default: begin
        st_next.state = sh_pkg::SH_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg            <= '0;
      st_reg.state      <= sh_pkg::SH_IDLE;
      st_reg.pins.sel_n <= 1'b1;
      st_reg.pins.wr_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // write cycle total: setup+pulse+hold+recovery exceeds WC_CYC
  logic unused_wc;
  assign unused_wc = (WC_CYC == '0);

  // outputs
  assign req_ready_o        = (st_reg.state == sh_pkg::SH_IDLE);
  assign rd_valid_o         = st_reg.rd_valid;
  assign rd_data_o          = st_reg.rd_data;
  assign mem_sel_n_o        = st_reg.pins.sel_n;
  assign mem_wr_n_o         = st_reg.pins.wr_n;
  assign mem_word_address_o = st_reg.pins.word_address;
  assign mem_din_o          = st_reg.pins.din;
endmodule

/* File: testbench/sh_sram_monitor.sv */
`timescale 1ns/100ps
`include "sram_host_cfg.svh"
module sh_sram_monitor (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  req_valid_i,
  input wire logic                  req_ready_o,
  input wire sh_pkg::sh_req_t       req_i,
  input wire logic                  rd_valid_o,
  input wire logic                  mem_sel_n_o,
  input wire logic                  mem_wr_n_o,
  input wire logic [`SH_ADDR_W-1:0] mem_word_address_o,
  input wire logic                  mem_din_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // request taken in idle
  wire logic take = req_valid_i && req_ready_o;
  a_read_answer:
    assert property (take && !req_i.write |-> ##18 rd_valid_o)
    else $error("read answer not on time");
  a_pins_on_take:
    assert property (take |=> !mem_sel_n_o
      && mem_word_address_o == $past(req_i.addr))
    else $error("select or address wrong after take");
  a_strobe_width:
    assert property ($fell(mem_wr_n_o) |-> !mem_wr_n_o[*8] ##1 mem_wr_n_o)
    else $error("write strobe width wrong");
  a_addr_setup:
    assert property ($fell(mem_wr_n_o)
      |-> $past(mem_word_address_o, 3) == mem_word_address_o)
    else $error("address setup short");
  a_write_end:
    assert property ($rose(mem_wr_n_o) |-> !$past(mem_sel_n_o, 11)
      && $past(mem_word_address_o, 11) == mem_word_address_o)
    else $error("select or address too late before strobe end");
  a_data_setup_hold:
    assert property ($rose(mem_wr_n_o)
      |-> $past(mem_din_o, 6) == mem_din_o ##1 $stable(mem_din_o))
    else $error("write data setup or hold short");
  a_addr_cycle:
    assert property ($changed(mem_word_address_o) |=>
      $stable(mem_word_address_o)[*8] ##1 $stable(mem_word_address_o)[*5])
    else $error("address cycle short");
  a_read_recover:
    assert property (rd_valid_o |-> mem_sel_n_o ##1 !req_ready_o[*8]
      ##1 req_ready_o)
    else $error("recovery after read wrong");
  a_no_idle_strobe:
    assert property (mem_sel_n_o |-> mem_wr_n_o)
    else $error("strobe low while deselected");
endmodule

bind sh_sram_host sh_sram_monitor u_mon (.sys_clk_i, .rst_n_i,
  .req_valid_i, .req_ready_o, .req_i, .rd_valid_o, .mem_sel_n_o,
  .mem_wr_n_o, .mem_word_address_o, .mem_din_o);

/* File: testbench/sh_sram_model.sv */
`timescale 1ns/100ps
module sh_sram_model #(
  parameter int ACC_NS = 70
) (
  input  wire logic        sel_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] word_address_i,
  input  wire logic        din_i,
  output logic             dout_o
);
  logic mem [65536];
  logic rd_ok;
  // store when the first of select or strobe rises
  always @(posedge sel_n_i or posedge wr_n_i) begin
    if ((sel_n_i ^ wr_n_i) === 1'b1) begin
      mem[word_address_i] = din_i;
    end
  end
  // access timer restarts on any select, strobe or address change, old data kept 5 ns
  always @(sel_n_i or wr_n_i or word_address_i) begin
    rd_ok <= #5 1'b0;
    rd_ok <= #(ACC_NS) 1'b1;
  end
  // released output shows the inverse value
  assign dout_o = (rd_ok && !sel_n_i && wr_n_i)
                  ? mem[word_address_i] : ~mem[word_address_i];
endmodule

/* File: testbench/sh_sram_host_test.sv */
`timescale 1ns/100ps
module sh_sram_host_test;
  logic            sys_clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            req_valid_i = 1'b0;
  sh_pkg::sh_req_t req_i = '0;
  logic            req_ready_o, rd_valid_o, rd_data_o, mem_dout_i;
  logic            mem_sel_n_o, mem_wr_n_o, mem_din_o;
  logic [15:0]     mem_word_address_o;
  int              n_fail = 0;
  int              tests_run = 0;
  // design and memory model
  sh_sram_host dut (.sys_clk_i, .rst_n_i, .req_valid_i, .req_ready_o,
    .req_i, .rd_valid_o, .rd_data_o, .mem_sel_n_o, .mem_wr_n_o,
    .mem_word_address_o, .mem_din_o, .mem_dout_i);
  sh_sram_model #(.ACC_NS(70)) u_mem (.sel_n_i(mem_sel_n_o),
    .wr_n_i(mem_wr_n_o), .word_address_i(mem_word_address_o),
    .din_i(mem_din_o), .dout_o(mem_dout_i));
  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for a flag, seen at the falling edge
  task automatic wait_hi(ref logic f);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (f !== 1'b1 && k < 60);
    if (f !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask
  // one request held until taken; reads return the bit
  task automatic access(input logic wr, input logic [15:0] a,
                        input logic d, output logic q);
    @(posedge sys_clk_i);
    req_i <= '{write: wr, addr: a, wdata: d};
    req_valid_i <= 1'b1;
    wait_hi(req_ready_o);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    q = 1'bx;
    if (!wr) begin
      wait_hi(rd_valid_o);
      q = rd_data_o;
    end
  endtask
  task automatic test_spread();
    logic q;
    for (int i = 0; i < 16; i++) begin
      access(i < 8, 16'(i % 8) * 16'h2493, i[0], q);
      if (i >= 8) check(q, i[0]);
    end
    $display("test_spread done");
  endtask
  task automatic test_overwrite();
    logic q;
    access(1'b1, 16'h5a5a, 1'b0, q);
    access(1'b1, 16'h5a5a, 1'b1, q);
    access(1'b1, 16'h5a5b, 1'b0, q);
    access(1'b0, 16'h5a5a, 1'b0, q);
    check(q, 1'b1);
    access(1'b0, 16'h5a5b, 1'b1, q);
    check(q, 1'b0);
    $display("test_overwrite done");
  endtask
  // reset in mid-strobe, then stored data still readable
  task automatic test_reset();
    logic q;
    @(posedge sys_clk_i);
    req_i <= '{write: 1'b1, addr: 16'h0f0f, wdata: 1'b1};
    req_valid_i <= 1'b1;
    wait_hi(req_ready_o);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    // strobe is low from the fourth cycle after the take
    repeat (6) @(posedge sys_clk_i);
    check(mem_wr_n_o, 1'b0);
    rst_n_i <= 1'b0;
    @(negedge sys_clk_i);
    check(mem_sel_n_o, 1'b1);
    check(mem_wr_n_o, 1'b1);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    access(1'b0, 16'h5a5a, 1'b0, q);
    check(q, 1'b1);
    $display("test_reset done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    test_spread();
    test_overwrite();
    test_reset();
    final_report();
  end
endmodule
